// ===== dgpb_pkg.sv
/*
 package for the dual gpio port bank: register indices, field positions,
 reset values and the bus request carrier.
 assumes a single 25 MHz clock domain and an avalon-mm master in front.
*/
package dgpb_pkg;
    // clock rate of i_clk in hz
    localparam int unsigned CLK_HZ       = 25000000;
    // bus geometry: byte address, word index = address[9:2]
    localparam int unsigned ADDR_W       = 10;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned IDX_LSB      = 2;
    localparam int unsigned IDX_W        = 8;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_P7_DIR    = 8'hE0;
    localparam logic [7:0] IDX_P7_DATA   = 8'hE1;
    localparam logic [7:0] IDX_P7_INV    = 8'hE2;
    localparam logic [7:0] IDX_P7_STAT   = 8'hE3;
    localparam logic [7:0] IDX_P8_DIR    = 8'hE4;
    localparam logic [7:0] IDX_P8_DATA   = 8'hE5;
    localparam logic [7:0] IDX_P8_INV    = 8'hE6;
    localparam logic [7:0] IDX_P8_STAT   = 8'hE7;
    localparam logic [7:0] IDX_P7_FSEL   = 8'hEC;
    localparam logic [7:0] IDX_P8_FSEL   = 8'hED;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'hF0;
    localparam logic [7:0] IDX_IRQ_CLR   = 8'hF1;
    localparam logic [7:0] IDX_IRQ_EN    = 8'hF2;
    // reset values
    localparam logic [3:0] P7_DIR_RST    = 4'hF;
    localparam logic [7:0] P8_DIR_RST    = 8'hFF;
    localparam logic [7:0] ZERO8         = 8'h00;
    // port seven function select bit positions
    localparam int unsigned P7_BEEP_BIT  = 5;
    localparam int unsigned P7_GRN_BIT   = 4;
    // port eight function select alternate maps
    localparam logic [7:0] P8_BEEP_MASK  = 8'h44;
    localparam logic [7:0] P8_SMI_MASK   = 8'h22;
    localparam logic [7:0] P8_YLW_MASK   = 8'h08;
    // interrupt status bits
    localparam int unsigned IRQ_P7_BIT   = 0;
    localparam int unsigned IRQ_P8_BIT   = 1;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [3:0]        byteenable;
        logic [DATA_W-1:0] writedata;
    } dgpb_avs_req_t;
endpackage : dgpb_pkg

// ===== dgpb_top.sv
/*
 dual gpio port bank: a four-pin and an eight-pin general purpose port with
 direction, data, inversion, read-to-clear edge status and function select.
 assumes one clock, synchronous resets, pins already synchronous to i_clk,
 and a single avalon-mm master that holds its request while waitrequest is high.
*/
// Summary of operation
// - a pin edge of either direction sets that pin's event status bit, else it stays zero.
// - a bus read of a status register clears the bits it returned; an edge in the same cycle still sets its bit.
// - port seven status sits in bits 3..0 in pin order, bits 7..4 read zero.
// - port eight status bits 7..0 map to pins 7..0 and reset to zero.
// - a port eight direction bit of 0 makes the pin an output, 1 an input.
// - port eight direction resets to all ones so every pin starts as input.
// - an output pin's data bit is stored, read back and driven on the pin.
// - an input pin's data bit reads the pin level and ignores writes.
// - an inversion bit of 1 inverts between register bit and pin both ways.
// - port seven select bit 5 routes beep to pin 5 and bit 4 the green led to pin 4.
// - port eight select routes beep to pins 6 and 2, smi to 5 and 1, yellow led to 3.
// - port eight data, inversion, status and select reset to zero on its standby reset.
// - port seven uses bits 3..0 the same way and its direction resets to 0Fh.
`timescale 1ns/10ps
`default_nettype none
module dgpb_top (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_port_seven_standby_reset,
    input  wire logic                  i_port_eight_standby_reset,
    input  wire dgpb_pkg::dgpb_avs_req_t i_avs,
    output logic                       o_avs_waitrequest,
    output logic [dgpb_pkg::DATA_W-1:0] o_avs_readdata,
    input  wire logic [3:0]            i_port_seven_pins,
    output logic [5:0]                 o_port_seven_out,
    output logic [5:0]                 o_port_seven_oe,
    input  wire logic [7:0]            i_port_eight_pins,
    output logic [7:0]                 o_port_eight_out,
    output logic [7:0]                 o_port_eight_oe,
    input  wire logic                  i_beep,
    input  wire logic                  i_smi,
    input  wire logic                  i_green_led_output,
    input  wire logic                  i_yellow_led_output,
    output logic                       o_irq
);
    import dgpb_pkg::*;

    logic              wait_reg;
    logic [31:0]       rdata_reg;
    logic [31:0]       rd_mux;
    logic [7:0]        idx;
    logic              req;
    logic              prep;
    logic              take_rd;
    logic              take_wr;
    logic              rst7;
    logic              rst8;
    logic [3:0]        p7_dir_reg;
    logic [3:0]        p7_data_reg;
    logic [3:0]        p7_inv_reg;
    logic [3:0]        p7_stat_reg;
    logic [7:0]        p7_fsel_reg;
    logic [7:0]        p8_dir_reg;
    logic [7:0]        p8_data_reg;
    logic [7:0]        p8_inv_reg;
    logic [7:0]        p8_stat_reg;
    logic [7:0]        p8_fsel_reg;
    logic [3:0]        p7_s1_reg;
    logic [3:0]        p7_s2_reg;
    logic [3:0]        p7_prev_reg;
    logic [7:0]        p8_s1_reg;
    logic [7:0]        p8_s2_reg;
    logic [7:0]        p8_prev_reg;
    logic [3:0]        p7_edge;
    logic [7:0]        p8_edge;
    logic [1:0]        irq_stat_reg;
    logic [1:0]        irq_en_reg;
    logic [1:0]        irq_ev;
    logic [7:0]        p8_out_next;
    logic [7:0]        wbyte;

    assign idx     = i_avs.address[IDX_LSB +: IDX_W];
    assign req     = i_avs.read | i_avs.write;
    assign prep    = req & wait_reg;
    assign take_rd = i_avs.read & ~wait_reg;
    assign take_wr = i_avs.write & ~wait_reg & i_avs.byteenable[0];
    assign wbyte   = i_avs.writedata[7:0];
    assign rst7    = i_rst | i_port_seven_standby_reset;
    assign rst8    = i_rst | i_port_eight_standby_reset;

    // one wait cycle per request: the answer is taken on the second edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~prep;
        end
    end

    // input pins read back through the inversion
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            IDX_P7_DIR:   rd_mux[3:0] = p7_dir_reg;
            IDX_P7_DATA:  rd_mux[3:0] = (p7_dir_reg & (p7_s2_reg ^ p7_inv_reg))
                                      | (~p7_dir_reg & p7_data_reg);
            IDX_P7_INV:   rd_mux[3:0] = p7_inv_reg;
            IDX_P7_STAT:  rd_mux[3:0] = p7_stat_reg;
            IDX_P8_DIR:   rd_mux[7:0] = p8_dir_reg;
            IDX_P8_DATA:  rd_mux[7:0] = (p8_dir_reg & (p8_s2_reg ^ p8_inv_reg))
                                      | (~p8_dir_reg & p8_data_reg);
            IDX_P8_INV:   rd_mux[7:0] = p8_inv_reg;
            IDX_P8_STAT:  rd_mux[7:0] = p8_stat_reg;
            IDX_P7_FSEL:  rd_mux[7:0] = p7_fsel_reg;
            IDX_P8_FSEL:  rd_mux[7:0] = p8_fsel_reg;
            IDX_IRQ_STAT: rd_mux[1:0] = irq_stat_reg;
            IDX_IRQ_EN:   rd_mux[1:0] = irq_en_reg;
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is captured a cycle early so it stands at the taking edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (prep & i_avs.read) begin
            rdata_reg <= rd_mux;
        end
    end

    // two-stage sync then compare successive samples
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            p7_s1_reg   <= 4'h0;
            p7_s2_reg   <= 4'h0;
            p7_prev_reg <= 4'h0;
            p8_s1_reg   <= 8'h00;
            p8_s2_reg   <= 8'h00;
            p8_prev_reg <= 8'h00;
        end else begin
            p7_s1_reg   <= i_port_seven_pins;
            p7_s2_reg   <= p7_s1_reg;
            p7_prev_reg <= p7_s2_reg;
            p8_s1_reg   <= i_port_eight_pins;
            p8_s2_reg   <= p8_s1_reg;
            p8_prev_reg <= p8_s2_reg;
        end
    end

    assign p7_edge = p7_s2_reg ^ p7_prev_reg;
    assign p8_edge = p8_s2_reg ^ p8_prev_reg;

    // port seven configuration, direction resets to inputs
    always_ff @(posedge i_clk) begin
        if (rst7) begin
            p7_dir_reg  <= P7_DIR_RST;
            p7_data_reg <= 4'h0;
            p7_inv_reg  <= 4'h0;
            p7_fsel_reg <= ZERO8;
        end else if (take_wr) begin
            case (idx)
                IDX_P7_DIR:  p7_dir_reg  <= wbyte[3:0];
                // input bits keep their stored value
                IDX_P7_DATA: p7_data_reg <= (p7_data_reg & p7_dir_reg)
                                          | (wbyte[3:0] & ~p7_dir_reg);
                IDX_P7_INV:  p7_inv_reg  <= wbyte[3:0];
                // only the two select bits with an alternate are kept
                IDX_P7_FSEL: p7_fsel_reg <= wbyte & 8'h30;
                default:     p7_dir_reg  <= p7_dir_reg;
            endcase
        end
    end

    // port eight configuration under its standby reset
    always_ff @(posedge i_clk) begin
        if (rst8) begin
            p8_dir_reg  <= P8_DIR_RST;
            p8_data_reg <= ZERO8;
            p8_inv_reg  <= ZERO8;
            p8_fsel_reg <= ZERO8;
        end else if (take_wr) begin
            case (idx)
                IDX_P8_DIR:  p8_dir_reg  <= wbyte;
                IDX_P8_DATA: p8_data_reg <= (p8_data_reg & p8_dir_reg)
                                          | (wbyte & ~p8_dir_reg);
                IDX_P8_INV:  p8_inv_reg  <= wbyte;
                IDX_P8_FSEL: p8_fsel_reg <= wbyte;
                default:     p8_dir_reg  <= p8_dir_reg;
            endcase
        end
    end

    // edge sets, read clears, the edge wins
    always_ff @(posedge i_clk) begin
        if (rst7) begin
            p7_stat_reg <= 4'h0;
        end else if (take_rd && idx == IDX_P7_STAT) begin
            // only bits already shown in the read data clear, so a late edge is kept
            p7_stat_reg <= (p7_stat_reg & ~rdata_reg[3:0]) | p7_edge;
        end else begin
            p7_stat_reg <= p7_stat_reg | p7_edge;
        end
    end

    // port eight status, set wins over the clearing read
    always_ff @(posedge i_clk) begin
        if (rst8) begin
            p8_stat_reg <= ZERO8;
        end else if (take_rd && idx == IDX_P8_STAT) begin
            // read data was captured a cycle early: clear only what it reported
            p8_stat_reg <= (p8_stat_reg & ~rdata_reg[7:0]) | p8_edge;
        end else begin
            p8_stat_reg <= p8_stat_reg | p8_edge;
        end
    end

    // interrupt status: sticky, set wins over the clear register
    assign irq_ev = {|p8_edge, |p7_edge};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_reg <= 2'h0;
            irq_en_reg   <= 2'h0;
            o_irq        <= 1'b0;
        end else begin
            if (take_wr && idx == IDX_IRQ_CLR) begin
                irq_stat_reg <= (irq_stat_reg & ~wbyte[1:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
            if (take_wr && idx == IDX_IRQ_EN) begin
                irq_en_reg <= wbyte[1:0];
            end
            o_irq <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // per-pin alternate mux for port eight
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_p8_mux
            always_comb begin
                if (p8_fsel_reg[gi] && P8_BEEP_MASK[gi]) begin
                    p8_out_next[gi] = i_beep;
                end else if (p8_fsel_reg[gi] && P8_SMI_MASK[gi]) begin
                    p8_out_next[gi] = i_smi;
                end else if (p8_fsel_reg[gi] && P8_YLW_MASK[gi]) begin
                    p8_out_next[gi] = i_yellow_led_output;
                end else begin
                    p8_out_next[gi] = p8_data_reg[gi] ^ p8_inv_reg[gi];
                end
            end
        end
    endgenerate

    // pins driven from flops, data inverted on the way out where its inversion bit is 1
    always_ff @(posedge i_clk) begin
        if (rst8) begin
            o_port_eight_out <= ZERO8;
            o_port_eight_oe  <= ZERO8;
        end else begin
            o_port_eight_out <= p8_out_next;
            o_port_eight_oe  <= ~p8_dir_reg;
        end
    end

    // pins 5 and 4 exist only for their alternates
    always_ff @(posedge i_clk) begin
        if (rst7) begin
            o_port_seven_out <= 6'h00;
            o_port_seven_oe  <= 6'h00;
        end else begin
            o_port_seven_out[3:0]         <= p7_data_reg ^ p7_inv_reg;
            o_port_seven_oe[3:0]          <= ~p7_dir_reg;
            o_port_seven_out[P7_BEEP_BIT] <= p7_fsel_reg[P7_BEEP_BIT] & i_beep;
            o_port_seven_oe[P7_BEEP_BIT]  <= p7_fsel_reg[P7_BEEP_BIT];
            o_port_seven_out[P7_GRN_BIT]  <= p7_fsel_reg[P7_GRN_BIT] & i_green_led_output;
            o_port_seven_oe[P7_GRN_BIT]   <= p7_fsel_reg[P7_GRN_BIT];
        end
    end

    assign o_avs_waitrequest = wait_reg;
    assign o_avs_readdata    = rdata_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    status_set_a: assert property (
        (p8_edge[0] && !i_port_eight_standby_reset) |=> p8_stat_reg[0])
        else $error("edge did not set status");
    read_clear_a: assert property (
        (take_rd && idx == IDX_P8_STAT && p8_edge == 8'h00)
        |=> (p8_stat_reg & $past(o_avs_readdata[7:0])) == 8'h00)
        else $error("status not cleared by read");
    stat_upper_a: assert property (
        (prep && i_avs.read && idx == IDX_P7_STAT) |=> o_avs_readdata[31:4] == 28'h0)
        else $error("port seven status upper bits not zero");
    dir_drive_a: assert property (
        !$past(rst8) |-> o_port_eight_oe == ~$past(p8_dir_reg))
        else $error("output enable does not follow direction");
    dir_reset_a: assert property (
        $past(i_port_eight_standby_reset) |-> p8_dir_reg == 8'hFF && o_port_eight_oe == 8'h00)
        else $error("direction reset value wrong");
    out_value_a: assert property (
        !$past(rst8) |-> o_port_eight_out[0] == ($past(p8_data_reg[0]) ^ $past(p8_inv_reg[0])))
        else $error("pin 0 output value wrong");
    input_ignore_a: assert property (
        (take_wr && idx == IDX_P8_DATA && p8_dir_reg[0] && !rst8)
        |=> p8_data_reg[0] == $past(p8_data_reg[0]))
        else $error("write to input pin changed data");
    read_invert_a: assert property (
        (prep && i_avs.read && idx == IDX_P8_DATA && p8_dir_reg[1])
        |=> o_avs_readdata[1] == $past(p8_s2_reg[1] ^ p8_inv_reg[1]))
        else $error("input read not inverted");
    beep_route_a: assert property (
        (p7_fsel_reg[5] && !rst7) |=> o_port_seven_out[5] == $past(i_beep))
        else $error("beep not routed to port seven pin 5");
    smi_route_a: assert property (
        (p8_fsel_reg[1] && !rst8) |=> o_port_eight_out[1] == $past(i_smi))
        else $error("smi not routed to port eight pin 1");
    set_wins_a: assert property (
        (take_rd && idx == IDX_P7_STAT && p7_edge[2] && !rst7) |=> p7_stat_reg[2])
        else $error("edge lost during clearing read");

    grp8_reset_a: assert property (
        $past(i_port_eight_standby_reset) |-> p8_stat_reg == 8'h00 && p8_data_reg == 8'h00
            && p8_inv_reg == 8'h00 && p8_fsel_reg == 8'h00)
        else $error("port eight group reset values wrong");
    grp7_reset_a: assert property (
        $past(rst7) |-> p7_dir_reg == 4'hF && p7_stat_reg == 4'h0)
        else $error("port seven group reset values wrong");

    // status moves only on an edge or a read
    stat_hold_a: assert property (
        (p8_edge == 8'h00 && !(take_rd && idx == IDX_P8_STAT) && !rst8)
        |=> p8_stat_reg == $past(p8_stat_reg))
        else $error("port eight status moved without an edge");
    stat_map_a: assert property (
        (p8_edge[7] && !rst8) |=> p8_stat_reg[7])
        else $error("pin 7 edge missing from status bit 7");
    p7_stat_map_a: assert property (
        (p7_edge[0] && !rst7) |=> p7_stat_reg[0])
        else $error("port seven pin 0 edge missing");

    // output bits store and read back what was written
    out_store_a: assert property (
        (take_wr && idx == IDX_P8_DATA && !p8_dir_reg[2] && !rst8)
        |=> p8_data_reg[2] == $past(wbyte[2]))
        else $error("write to output pin not stored");
    out_readback_a: assert property (
        (prep && i_avs.read && idx == IDX_P8_DATA && !p8_dir_reg[0])
        |=> o_avs_readdata[0] == $past(p8_data_reg[0]))
        else $error("output pin read back wrong");

    // two more port eight alternates and a plain pin
    beep_route8_a: assert property (
        (p8_fsel_reg[6] && !rst8) |=> o_port_eight_out[6] == $past(i_beep))
        else $error("beep not routed to port eight pin 6");
    ylw_route_a: assert property (
        (p8_fsel_reg[3] && !rst8) |=> o_port_eight_out[3] == $past(i_yellow_led_output))
        else $error("yellow led not routed to port eight pin 3");
    plain_pin_a: assert property (
        !$past(rst8) |-> o_port_eight_out[7] == ($past(p8_data_reg[7]) ^ $past(p8_inv_reg[7])))
        else $error("pin 7 left its plain use");

    grn_route_a: assert property (
        (p7_fsel_reg[4] && !rst7) |=> o_port_seven_out[4] == $past(i_green_led_output))
        else $error("green led not routed to port seven pin 4");
    alt_enable_a: assert property (
        !$past(rst7) |-> o_port_seven_oe[5:4] == $past(p7_fsel_reg[5:4]))
        else $error("port seven alternate enable wrong");
    p7_dir_drive_a: assert property (
        !$past(rst7) |-> o_port_seven_oe[3:0] == ~$past(p7_dir_reg))
        else $error("port seven enable does not follow direction");
    p7_out_value_a: assert property (
        !$past(rst7) |-> o_port_seven_out[0] == ($past(p7_data_reg[0]) ^ $past(p7_inv_reg[0])))
        else $error("port seven pin 0 output value wrong");
endmodule : dgpb_top
`default_nettype wire

// ===== dgpb_board_model.sv
/*
 board model for the dual gpio port bank: resolves each pin from the
 design's drive and enable and from a level that the bench sets.
 assumes the bench changes board levels by non-blocking assignment.
*/
`timescale 1ns/10ps
`default_nettype none
module dgpb_board_model (
    input  wire logic [5:0] i_p7_out,
    input  wire logic [5:0] i_p7_oe,
    input  wire logic [3:0] i_p7_level,
    input  wire logic [7:0] i_p8_out,
    input  wire logic [7:0] i_p8_oe,
    input  wire logic [7:0] i_p8_level,
    output logic      [3:0] o_p7_pins,
    output logic      [7:0] o_p8_pins
);
    // a driving pin wins over the board, so output pins read back their drive
    assign o_p7_pins = (i_p7_oe[3:0] & i_p7_out[3:0]) | (~i_p7_oe[3:0] & i_p7_level);
    assign o_p8_pins = (i_p8_oe & i_p8_out) | (~i_p8_oe & i_p8_level);
endmodule : dgpb_board_model
`default_nettype wire

// ===== tb_top.sv
/*
 self-checking bench for the dual gpio port bank.
 assumes the avalon slave answers after one wait cycle and pins via the board model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dgpb_pkg::*;
    logic          i_clk;
    logic          i_rst;
    logic          p7_rst;
    logic          p8_rst;
    dgpb_avs_req_t avs;
    logic          waitreq;
    logic [31:0]   rdata;
    logic [3:0]    p7_pins;
    logic [5:0]    p7_out;
    logic [5:0]    p7_oe;
    logic [7:0]    p8_pins;
    logic [7:0]    p8_out;
    logic [7:0]    p8_oe;
    logic [3:0]    lvl7;
    logic [7:0]    lvl8;
    logic          beep;
    logic          smi;
    logic          green_led_output;
    logic          yellow_led_output;
    logic          irq;
    int            fails;
    int            checks;

    dgpb_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_port_seven_standby_reset(p7_rst),
        .i_port_eight_standby_reset(p8_rst), .i_avs(avs), .o_avs_waitrequest(waitreq),
        .o_avs_readdata(rdata), .i_port_seven_pins(p7_pins), .o_port_seven_out(p7_out),
        .o_port_seven_oe(p7_oe), .i_port_eight_pins(p8_pins), .o_port_eight_out(p8_out),
        .o_port_eight_oe(p8_oe), .i_beep(beep), .i_smi(smi), .i_green_led_output(green_led_output),
        .i_yellow_led_output(yellow_led_output), .o_irq(irq));
    dgpb_board_model board (.i_p7_out(p7_out), .i_p7_oe(p7_oe), .i_p7_level(lvl7),
        .i_p8_out(p8_out), .i_p8_oe(p8_oe), .i_p8_level(lvl8), .o_p7_pins(p7_pins),
        .o_p8_pins(p8_pins));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc

    // request held until waitrequest is sampled low, released after that edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge i_clk);
        avs <= '{read: !wr, write: wr, address: {idx, 2'b00}, byteenable: 4'hF,
                 writedata: {24'h0, wd}};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        rd = rdata;
        avs <= '0;
        if (n >= 50) begin
            fails++;
            end_of_test();
        end
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk(name, exp, x);
    endtask : rd_chk

    task automatic t_reset;
        rd_chk("p8 dir", IDX_P8_DIR, 32'h0000_00FF);
        rd_chk("p7 dir", IDX_P7_DIR, 32'h0000_000F);
        rd_chk("p8 inv", IDX_P8_INV, 32'h0000_0000);
        rd_chk("p8 fsel", IDX_P8_FSEL, 32'h0000_0000);
        rd_chk("p8 stat", IDX_P8_STAT, 32'h0000_0000);
        rd_chk("p7 fsel", IDX_P7_FSEL, 32'h0000_0000);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        chk("p8 oe", 32'h0, {24'h0, p8_oe});
    endtask : t_reset

    task automatic t_io;
        // direction 0 drives: low nibble out, high nibble in
        wr(IDX_P8_DIR, 8'hF0);
        wr(IDX_P8_DATA, 8'hA5);
        lvl8 <= 8'h30;
        cyc(4);
        chk("p8 oe", 32'h0F, {24'h0, p8_oe});
        chk("p8 out", 32'h5, {28'h0, p8_out[3:0]});
        rd_chk("p8 data", IDX_P8_DATA, 32'h0000_0035);
        wr(IDX_P8_INV, 8'hFF);
        cyc(3);
        chk("p8 out inv", 32'hA, {28'h0, p8_out[3:0]});
        rd_chk("p8 data inv", IDX_P8_DATA, 32'h0000_00C5);
        wr(IDX_P8_INV, 8'h00);
        wr(IDX_P7_DIR, 8'h0E);
        wr(IDX_P7_DATA, 8'h01);
        lvl7 <= 4'h4;
        cyc(4);
        chk("p7 out", 32'h1, {31'h0, p7_oe[0] & p7_out[0]});
        rd_chk("p7 data", IDX_P7_DATA, 32'h0000_0005);
    endtask : t_io

    task automatic t_edge;
        logic [31:0] x;
        cyc(5);
        bus(1'b0, IDX_P8_STAT, 8'h00, x);
        bus(1'b0, IDX_P7_STAT, 8'h00, x);
        wr(IDX_IRQ_CLR, 8'h03);
        wr(IDX_IRQ_EN, 8'h00);
        lvl8 <= 8'hB0;
        lvl7 <= 4'h0;
        cyc(5);
        rd_chk("p8 stat", IDX_P8_STAT, 32'h0000_0080);
        rd_chk("p8 stat again", IDX_P8_STAT, 32'h0000_0000);
        wr(IDX_P8_STAT, 8'hFF);
        rd_chk("p8 stat ro", IDX_P8_STAT, 32'h0000_0000);
        rd_chk("p7 stat", IDX_P7_STAT, 32'h0000_0004);
        // edge lands at the capture edge of the read: reported by the next read
        lvl7 <= 4'h4;
        cyc(1);
        rd_chk("p7 stat early", IDX_P7_STAT, 32'h0000_0000);
        rd_chk("p7 stat late", IDX_P7_STAT, 32'h0000_0004);
        // edge lands at the clearing edge of the read: set wins
        lvl7 <= 4'h0;
        rd_chk("p7 stat race", IDX_P7_STAT, 32'h0000_0000);
        rd_chk("p7 stat kept", IDX_P7_STAT, 32'h0000_0004);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk("irq stat", IDX_IRQ_STAT, 32'h0000_0003);
        wr(IDX_IRQ_EN, 8'h02);
        cyc(2);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(IDX_IRQ_CLR, 8'h02);
        cyc(2);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask : t_edge

    task automatic t_fsel;
        logic [2:0] src [2] = '{3'b101, 3'b010};
        wr(IDX_P7_FSEL, 8'h30);
        beep <= 1'b1;
        green_led_output <= 1'b0;
        cyc(3);
        chk("p7 alt oe", 32'h3, {30'h0, p7_oe[5:4]});
        chk("p7 alt out", 32'h2, {30'h0, p7_out[5:4]});
        // software also makes the alternate pins outputs
        wr(IDX_P8_DIR, 8'h00);
        wr(IDX_P8_DATA, 8'h00);
        wr(IDX_P8_FSEL, 8'h6E);
        for (int i = 0; i < 2; i++) begin
            {beep, smi, yellow_led_output} <= src[i];
            green_led_output <= src[i][1];
            cyc(3);
            chk("p8 alt out", {24'h0, (src[i][2] ? 8'h44 : 8'h00) | (src[i][1] ? 8'h22 : 8'h00)
                | (src[i][0] ? 8'h08 : 8'h00)}, {24'h0, p8_out});
            chk("p7 alt out", {30'h0, src[i][2], src[i][1]}, {30'h0, p7_out[5:4]});
        end
        wr(IDX_P8_INV, 8'h5A);
        p8_rst <= 1'b1;
        cyc(2);
        p8_rst <= 1'b0;
        rd_chk("p8 dir grp", IDX_P8_DIR, 32'h0000_00FF);
        rd_chk("p8 fsel grp", IDX_P8_FSEL, 32'h0000_0000);
        rd_chk("p8 inv grp", IDX_P8_INV, 32'h0000_0000);
        rd_chk("p7 fsel kept", IDX_P7_FSEL, 32'h0000_0030);
        p7_rst <= 1'b1;
        cyc(2);
        p7_rst <= 1'b0;
        rd_chk("p7 dir grp", IDX_P7_DIR, 32'h0000_000F);
        rd_chk("p7 fsel grp", IDX_P7_FSEL, 32'h0000_0000);
    endtask : t_fsel

    initial begin
        fails = 0;
        checks = 0;
        i_rst = 1'b1;
        p7_rst = 1'b0;
        p8_rst = 1'b0;
        avs = '0;
        lvl7 = 4'h0;
        lvl8 = 8'h00;
        {beep, smi, green_led_output, yellow_led_output} = 4'h0;
        cyc(6);
        i_rst <= 1'b0;
        cyc(2);
        t_reset();
        t_io();
        t_edge();
        t_fsel();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
